// [verif/fic_top_asserts.sv]
`timescale 1ns/1ps
module fic_top_asserts #(
  parameter logic [4:0] REC_IDX = 5'h00
) (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire fic_pkg::fic_support_t sup,
  input wire logic                  rd_en,
  input wire logic [11:0]           rd_off,
  input wire logic [63:0]           rd_data,
  input wire logic                  sysreg_rd,
  input wire logic [63:0]           sysreg_data,
  input wire fic_pkg::fic_ctl_t     ctl,
  input wire logic                  ctl_av_rd,
  input wire logic                  inj_rec,
  input wire fic_pkg::fic_sts_t     norm_sts,
  input wire logic                  addr_wr,
  input wire logic [63:0]           addr_wdata,
  input wire logic [63:0]           fault_addr,
  input wire fic_pkg::fic_sts_t     sts
);
  // ************************************************************
  // Checks
  // ************************************************************
  // Offset worked out here, not from the package constants
  wire logic [11:0] own_off = 12'h0800 + {REC_IDX, 6'h00};
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_rd_upper_zero: assert property (
    rd_en |=> rd_data[63:12] == '0)
    else $error("capability upper bits not zero");
  chk_rd_bad_off: assert property (
    rd_en && rd_off != own_off |=> rd_data == '0)
    else $error("foreign offset returned data");
  chk_rd_both_ways: assert property (rd_en && sysreg_rd && rd_off == own_off
    |=> rd_data == sysreg_data)
    else $error("mapped and system views differ");
  chk_ce_not_rsvd: assert property (sysreg_rd |=> sysreg_data[7:6] != 2'h2)
    else $error("reserved corrected encoding seen");
  chk_ce_unsup: assert property (sysreg_rd && sup.feature_ext_present && !sup.ce
    |=> sysreg_data[7:6] == 2'h0)
    else $error("corrected field set while unsupported");
  chk_poison_unsup: assert property (sysreg_rd && !sup.poison
    |=> !sysreg_data[10])
    else $error("poison capability set while unsupported");
  chk_addr_kept: assert property (inj_rec && !addr_wr |=> $stable(fault_addr))
    else $error("fault location changed by injection");
  chk_av_from_ctl: assert property (inj_rec
    |=> sts.addr_valid == $past(ctl_av_rd))
    else $error("address valid not taken from control");
  chk_abort_normal: assert property (
    inj_rec && !sup.abort_signaled
    |=> sts.abort_signaled_flag == $past(norm_sts.abort_signaled_flag))
    else $error("abort flag not set by normal rules");
  chk_ovf_from_ctl: assert property (inj_rec && sup.overflow
    |=> sts.overflow_flag == $past(ctl.overflow_flag))
    else $error("overflow flag not taken from control");
  chk_addr_write: assert property (addr_wr && !sts.addr_valid && !inj_rec
    |=> fault_addr == $past(addr_wdata))
    else $error("fault location write lost");
  chk_addr_locked: assert property (addr_wr && sts.addr_valid && !inj_rec
    |=> $stable(fault_addr))
    else $error("fault location written while valid");
endmodule : fic_top_asserts
bind fic_top fic_top_asserts #(.REC_IDX(REC_IDX)) u_chk (.clock(clock),
  .rst_n(rst_n), .sup(sup), .rd_en(rd_en), .rd_off(rd_off),
  .rd_data(rd_data), .sysreg_rd(sysreg_rd), .sysreg_data(sysreg_data),
  .ctl(ctl), .ctl_av_rd(ctl_av_rd), .inj_rec(inj_rec),
  .norm_sts(norm_sts), .addr_wr(addr_wr),
  .addr_wdata(addr_wdata), .fault_addr(fault_addr), .sts(sts));

// [verif/fic_top_bench.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
module fic_top_bench;
  logic clock = 0, rst_n = 0, rd_en = 0, sysreg_rd = 0, inj_rec = 0;
  logic inj_addr_ok = 1, addr_wr = 0, av_clr = 0, ctl_av_rd;
  logic [11:0] rd_off = 12'h000;
  logic [63:0] rd_data, sysreg_data, fault_addr;
  logic [63:0] inj_addr = 64'hffff_0000_ffff_0000;
  logic [63:0] addr_wdata = 64'h1234_5678_9abc_def0;
  fic_pkg::fic_support_t sup = 11'h7ff;
  fic_pkg::fic_ctl_t ctl = 5'h00;
  fic_pkg::fic_sts_t norm_sts = 5'h00, sts;
  int n_fail = 0, compares = 0;
  // Support pattern beside the capability it should give
  logic [22:0] rows [8] = '{{11'h7ff, 12'hfff}, {11'h400, 12'h800},
    {11'h000, 12'h8fe}, {11'h5ff, 12'hf3f}, {11'h408, 12'hc00},
    {11'h500, 12'h820}, {11'h402, 12'h900}, {11'h405, 12'ha01}};
  always #5 clock = ~clock;
  fic_top #(.REC_IDX(5'h02)) dut (.clock(clock), .rst_n(rst_n), .sup(sup),
    .rd_en(rd_en), .rd_off(rd_off), .rd_data(rd_data),
    .sysreg_rd(sysreg_rd), .sysreg_data(sysreg_data), .ctl(ctl),
    .ctl_av_rd(ctl_av_rd), .inj_rec(inj_rec), .inj_addr_ok(inj_addr_ok),
    .inj_addr(inj_addr), .norm_sts(norm_sts), .addr_wr(addr_wr),
    .addr_wdata(addr_wdata), .av_clr(av_clr), .fault_addr(fault_addr),
    .sts(sts));
  // ************************************************************
  // Tasks
  // ************************************************************
  task step;
    @(posedge clock);
    #1;
  endtask : step
  task rd(input logic [11:0] off);
    rd_en = 1;
    sysreg_rd = 1;
    rd_off = off;
    step;
    rd_en = 0;
    sysreg_rd = 0;
    // Idle cycle so back-to-back reads never retoggle in one step
    step;
  endtask : rd
  task inj(input fic_pkg::fic_ctl_t c, input fic_pkg::fic_sts_t n);
    ctl = c;
    norm_sts = n;
    inj_rec = 1;
    step;
    inj_rec = 0;
  endtask : inj
  task tally_and_finish;
    if (n_fail == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // ************************************************************
  // Sequence
  // ************************************************************
  initial
  begin
    repeat (4) @(posedge clock);
    `CHK("sts_reset", 5'h00, sts)
    #1 rst_n = 1;
    foreach (rows[i])
    begin
      sup = rows[i][22:12];
      rd(12'h0880);
      `CHK("cap_mm", {52'h0, rows[i][11:0]}, rd_data)
      `CHK("cap_sys", {52'h0, rows[i][11:0]}, sysreg_data)
    end
    rd(12'h0800);
    `CHK("cap_foreign", 64'h0, rd_data)
    sup = 11'h7ff;
    ctl = 5'h10;
    #1 `CHK("ctl_av_rd", 1'b1, ctl_av_rd)
    addr_wr = 1;
    step;
    addr_wr = 0;
    `CHK("addr_preload", addr_wdata, fault_addr)
    inj(5'h16, 5'h09);
    `CHK("sts_from_ctl", 5'h16, sts)
    `CHK("addr_kept", 64'h1234_5678_9abc_def0, fault_addr)
    addr_wdata = 64'h0000_1111_2222_3333;
    addr_wr = 1;
    step;
    addr_wr = 0;
    `CHK("addr_locked", 64'h1234_5678_9abc_def0, fault_addr)
    av_clr = 1;
    step;
    av_clr = 0;
    `CHK("av_cleared", 1'b0, sts.addr_valid)
    sup = 11'h400;
    inj(5'h00, 5'h05);
    `CHK("abort_normal", 1'b1, sts.abort_signaled_flag)
    `CHK("ovf_normal", 1'b1, sts.overflow_flag)
    `CHK("av_ctl_zero", 1'b0, sts.addr_valid)
    tally_and_finish;
  end
endmodule : fic_top_bench

// [verilog/fic_cap_mask.sv]
`timescale 1ns/1ps
module fic_cap_mask (
  input  wire fic_pkg::fic_cap_t     cap_raw,
  input  wire fic_pkg::fic_support_t sup,
  output fic_pkg::fic_cap_t          cap
);

  // ****************************************************************
  // Support masking
  // ****************************************************************
  logic sel;
  logic [1:0] ce_v;

  always_comb
  begin
    // Without extended features the CE and generation types are taken as supported
    sel = sup.feature_ext_present;
    ce_v = cap_raw.ce_gen;
    if (ce_v == fic_pkg::CE_RSVD)
    begin
      ce_v = fic_pkg::CE_NONE;
    end
    cap.addr_syndrome       = cap_raw.addr_syndrome;
    cap.poison_flag         = cap_raw.poison_flag
                              & sup.poison;
    cap.abort_signaled_flag = cap_raw.abort_signaled_flag
                              & sup.abort_signaled;
    cap.critical_flag       = cap_raw.critical_flag
                              & sup.critical;
    cap.ce_gen              = (sel & ~sup.ce) ? fic_pkg::CE_NONE
                                              : ce_v;
    cap.postponed_gen       = cap_raw.postponed_gen
                              & (~sel | sup.postponed);
    cap.latent_gen          = cap_raw.latent_gen & (~sel | sup.latent);
    cap.recoverable_gen     = cap_raw.recoverable_gen
                              & (~sel | sup.recoverable);
    cap.unrecoverable_gen   = cap_raw.unrecoverable_gen
                              & (~sel | sup.unrecoverable);
    cap.uncontainable_gen   = cap_raw.uncontainable_gen
                              & (~sel | sup.uncontainable);
    cap.overflow_flag       = cap_raw.overflow_flag
                              & sup.overflow;
  end

endmodule : fic_cap_mask

// [verilog/fic_pkg.sv]
package fic_pkg;

  // ****************************************************************
  // Register placement
  // ****************************************************************
  localparam int unsigned REG_W           = 64;
  localparam logic [11:0] CAP_BASE_OFF    = 12'h0800;
  localparam logic [11:0] REC_STRIDE      = 12'h0040;
  localparam int unsigned REC_IDX_W       = 5;

  // ****************************************************************
  // Capability field positions
  // ****************************************************************
  localparam int unsigned BIT_ADDR_SYN    = 11;
  localparam int unsigned BIT_POISON      = 10;
  localparam int unsigned BIT_ABORT       = 9;
  localparam int unsigned BIT_CRIT        = 8;
  localparam int unsigned CE_HI           = 7;
  localparam int unsigned CE_LO           = 6;
  localparam int unsigned BIT_POSTPONED   = 5;
  localparam int unsigned BIT_LATENT      = 4;
  localparam int unsigned BIT_RECOV       = 3;
  localparam int unsigned BIT_UNRECOV     = 2;
  localparam int unsigned BIT_UNCONT      = 1;
  localparam int unsigned BIT_OVERFLOW    = 0;

  // ****************************************************************
  // Corrected-error capability encodings
  // ****************************************************************
  localparam logic [1:0] CE_NONE          = 2'h0;
  localparam logic [1:0] CE_NONSPEC       = 2'h1;
  localparam logic [1:0] CE_RSVD          = 2'h2;
  localparam logic [1:0] CE_TRANS_PERS    = 2'h3;
  localparam logic [1:0] STS_CE_NONSPEC   = 2'h2;
  localparam logic [1:0] STS_CE_TRANS     = 2'h1;
  localparam logic [1:0] STS_CE_PERS      = 2'h3;
  localparam logic [11:0] CAP_RESET       = 12'h000;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       addr_syndrome;
    logic       poison_flag;
    logic       abort_signaled_flag;
    logic       critical_flag;
    logic [1:0] ce_gen;
    logic       postponed_gen;
    logic       latent_gen;
    logic       recoverable_gen;
    logic       unrecoverable_gen;
    logic       uncontainable_gen;
    logic       overflow_flag;
  } fic_cap_t;

  // Per-type support from the record feature register
  typedef struct packed {
    logic feature_ext_present;
    logic ce;
    logic postponed;
    logic latent;
    logic recoverable;
    logic unrecoverable;
    logic uncontainable;
    logic poison;
    logic abort_signaled;
    logic critical;
    logic overflow;
  } fic_support_t;

  // Control register bits used when an injected error is recorded
  typedef struct packed {
    logic addr_syndrome;
    logic poison_flag;
    logic abort_signaled_flag;
    logic critical_flag;
    logic overflow_flag;
  } fic_ctl_t;

  // Flags as written into the record status on an injection
  typedef struct packed {
    logic addr_valid;
    logic poison_flag;
    logic abort_signaled_flag;
    logic critical_flag;
    logic overflow_flag;
  } fic_sts_t;

endpackage : fic_pkg

// [verilog/fic_top.sv]
`timescale 1ns/1ps
module fic_top #(
  parameter logic [1:0]  CE_CAP      = 2'h3,
  parameter logic        ADDR_CAP    = 1'b1,
  parameter logic        AV_FORCED   = 1'b0,
  parameter logic [fic_pkg::REC_IDX_W-1:0] REC_IDX = '0,
  parameter logic [10:0] GEN_CAP     = 11'h7ff,
  localparam int unsigned REC_IDX_W  = fic_pkg::REC_IDX_W
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire fic_pkg::fic_support_t sup,
  input  wire logic                  rd_en,
  input  wire logic [11:0]           rd_off,
  output logic [63:0]                rd_data,
  input  wire logic                  sysreg_rd,
  output logic [63:0]                sysreg_data,
  input  wire fic_pkg::fic_ctl_t     ctl,
  output logic                       ctl_av_rd,
  input  wire logic                  inj_rec,
  input  wire logic                  inj_addr_ok,
  input  wire logic [63:0]           inj_addr,
  input  wire fic_pkg::fic_sts_t     norm_sts,
  input  wire logic                  addr_wr,
  input  wire logic [63:0]           addr_wdata,
  input  wire logic                  av_clr,
  output logic [63:0]                fault_addr,
  output fic_pkg::fic_sts_t          sts
);

  // ****************************************************************
  // Capability value
  // ****************************************************************
  fic_pkg::fic_cap_t cap_raw;
  fic_pkg::fic_cap_t cap;
  logic [63:0]       cap_word;
  logic [11:0]       my_off;

  always_comb
  begin
    cap_raw                     = '0;
    cap_raw.addr_syndrome       = ADDR_CAP;
    cap_raw.ce_gen              = CE_CAP;
    cap_raw.poison_flag         = GEN_CAP[10];
    cap_raw.abort_signaled_flag = GEN_CAP[9];
    cap_raw.critical_flag       = GEN_CAP[8];
    cap_raw.postponed_gen       = GEN_CAP[5];
    cap_raw.latent_gen          = GEN_CAP[4];
    cap_raw.recoverable_gen     = GEN_CAP[3];
    cap_raw.unrecoverable_gen   = GEN_CAP[2];
    cap_raw.uncontainable_gen   = GEN_CAP[1];
    cap_raw.overflow_flag       = GEN_CAP[0];
  end

  fic_cap_mask u_mask (
    .cap_raw (cap_raw),
    .sup     (sup),
    .cap     (cap)
  );

  // Upper bits are reserved and read as zero
  assign cap_word = {52'h0, cap};
  assign my_off   = fic_pkg::CAP_BASE_OFF
                    + 12'(fic_pkg::REC_STRIDE * 12'(REC_IDX));

  // ****************************************************************
  // Read port, writes have no effect
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_data <= 64'h0000_0000_0000_0000;
    end
    else if (rd_en)
    begin
      rd_data <= (rd_off == my_off) ? cap_word : 64'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sysreg_data <= 64'h0000_0000_0000_0000;
    end
    else if (sysreg_rd)
    begin
      sysreg_data <= cap_word;
    end
  end

  // Control address bit reads one when forced
  assign ctl_av_rd = (cap.addr_syndrome && AV_FORCED) ? 1'b1
                                                      : ctl.addr_syndrome;

  // ****************************************************************
  // Fault location register
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fault_addr <= 64'h0000_0000_0000_0000;
    end
    else if (inj_rec && !cap.addr_syndrome && inj_addr_ok)
    begin
      fault_addr <= inj_addr;
    end
    else if (addr_wr && cap.addr_syndrome && !sts.addr_valid)
    begin
      // Preload only while no valid address is held
      fault_addr <= addr_wdata;
    end
  end

  // ****************************************************************
  // Status flags on a recorded injection
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sts <= '0;
    end
    else if (inj_rec)
    begin
      // Recording wins over a same-cycle clear, except when cap.addr_syndrome and inj_addr_ok are both low
      if (!cap.addr_syndrome)
      begin
        if (inj_addr_ok)
        begin
          sts.addr_valid <= 1'b1;
        end
        else if (av_clr)
        begin
          sts.addr_valid <= 1'b0;
        end
      end
      else
      begin
        sts.addr_valid <= AV_FORCED ? 1'b1 : ctl.addr_syndrome;
      end
      sts.poison_flag <= cap.poison_flag ? ctl.poison_flag
                                         : norm_sts.poison_flag;
      sts.abort_signaled_flag <= cap.abort_signaled_flag
                                 ? ctl.abort_signaled_flag
                                 : norm_sts.abort_signaled_flag;
      sts.critical_flag <= cap.critical_flag ? ctl.critical_flag
                                     : norm_sts.critical_flag;
      sts.overflow_flag <= cap.overflow_flag ? ctl.overflow_flag
                                     : norm_sts.overflow_flag;
    end
    else if (av_clr)
    begin
      sts.addr_valid <= 1'b0;
    end
  end

endmodule : fic_top
